//--- src/lpmw_ctrl.sv
// Low power mode sequencer with wake routing and leakage wake unit
//
// The address map and the plain strobed port were chosen for this implementation.
`timescale 1ns/10ps
module lpmw_ctrl (
	// Clock and reset
	input  wire logic             ref_clk_in,
	input  wire logic             reset_n_in,
	// Register port
	input  wire logic [3:0]       reg_addr_in,
	input  wire logic [7:0]       reg_wdata_in,
	input  wire logic             reg_wr_in,
	input  wire logic             reg_rd_in,
	output logic      [7:0]       reg_rdata_out,
	// Core
	input  wire logic             wait_for_interrupt_instr_in,
	input  wire logic             wait_for_event_instr_in,
	input  wire logic             vic_wake_in,
	input  wire logic             async_wake_in,
	// Wake sources: pins 5..10,14,15 in bits 0..7
	input  wire logic [7:0]       wake_pin_in,
	input  wire logic             low_power_timer_wake_in,
	input  wire logic             cmp_wake_in,
	input  wire logic             clock_alarm_wake_in,
	input  wire logic             clock_seconds_wake_in,
	// Mode outputs
	output lpmw_pkg::lpmw_mode_e  mode_out,
	output lpmw_pkg::lpmw_dom_s   domain_out,
	output logic                  periph_reset_out,
	output logic                  irq_out
);

	lpmw_pkg::lpmw_state_s state_reg;
	lpmw_pkg::lpmw_state_s state_next;

	logic [7:0] mod_src;
	logic       sleep_req;
	logic       pin_hit;
	logic       mod_hit;
	logic       wake_hit;
	logic       leaving_deep;
	logic       file_wr;
	// Backup file has no mode-dependent clear; file_retain is set in every level except LPMW_REDUCED_STOP
	logic [7:0] file_mem [lpmw_pkg::LPMW_FILE_BYTES];

	function automatic logic is_deep(input lpmw_pkg::lpmw_mode_e m);
		return (m == lpmw_pkg::LPMW_DEEP_RAM) || (m == lpmw_pkg::LPMW_DEEP_FILE) ||
			(m == lpmw_pkg::LPMW_DEEP_MIN);
	endfunction

	function automatic logic is_leak(input lpmw_pkg::lpmw_mode_e m);
		return (m == lpmw_pkg::LPMW_LEAKAGE_STOP) || is_deep(m);
	endfunction

	function automatic lpmw_pkg::lpmw_dom_s domains(input lpmw_pkg::lpmw_mode_e m,
			input logic por_en);
		lpmw_pkg::lpmw_dom_s d;
		d = '0;
		d.ctrl_run = 1'b1;
		d.sram_retain = 1'b1;
		d.file_retain = 1'b1;
		d.timer_run = 1'b1;
		d.clock_run = 1'b1;
		d.por_detect_en = 1'b1;
		unique case (m)
			lpmw_pkg::LPMW_RUN, lpmw_pkg::LPMW_REDUCED_RUN: begin
				d.core_clock_en = 1'b1;
				d.periph_clock_en = 1'b1;
				d.cmp_run = 1'b1;
				d.adc_run = 1'b1;
				d.pin_irq_run = 1'b1;
				d.dma_group_run = 1'b1;
				d.vic_en = 1'b1;
				d.reduced_clock = (m == lpmw_pkg::LPMW_REDUCED_RUN);
				d.low_voltage_monitor_en = (m == lpmw_pkg::LPMW_RUN);
			end
			lpmw_pkg::LPMW_WAIT, lpmw_pkg::LPMW_REDUCED_WAIT: begin
				d.periph_clock_en = 1'b1;
				d.cmp_run = 1'b1;
				d.adc_run = 1'b1;
				d.pin_irq_run = 1'b1;
				d.dma_group_run = 1'b1;
				d.vic_en = 1'b1;
				d.reduced_clock = (m == lpmw_pkg::LPMW_REDUCED_WAIT);
				d.low_voltage_monitor_en = (m == lpmw_pkg::LPMW_WAIT);
			end
			lpmw_pkg::LPMW_STOP: begin
				d.static_freeze = 1'b1;
				d.low_voltage_monitor_en = 1'b1;
				d.cmp_run = 1'b1;
				d.adc_run = 1'b1;
				d.pin_irq_run = 1'b1;
				d.async_wake_controller_en = 1'b1;
			end
			lpmw_pkg::LPMW_REDUCED_STOP: begin
				d.file_retain = 1'b0;
				d.static_freeze = 1'b1;
				d.reduced_clock = 1'b1;
				d.cmp_run = 1'b1;
				d.adc_run = 1'b1;
				d.dma_group_run = 1'b1;
				d.async_wake_controller_en = 1'b1;
			end
			lpmw_pkg::LPMW_LEAKAGE_STOP: begin
				d.static_freeze = 1'b1;
				d.port_hold = 1'b1;
				d.cmp_run = 1'b1;
				d.wake_unit_en = 1'b1;
			end
			lpmw_pkg::LPMW_DEEP_RAM: begin
				d.periph_power_off = 1'b1;
				d.port_hold = 1'b1;
				d.cmp_run = 1'b1;
				d.wake_unit_en = 1'b1;
			end
			lpmw_pkg::LPMW_DEEP_FILE: begin
				d.periph_power_off = 1'b1;
				d.sram_retain = 1'b0;
				d.port_hold = 1'b1;
				d.cmp_run = 1'b1;
				d.wake_unit_en = 1'b1;
			end
			lpmw_pkg::LPMW_DEEP_MIN: begin
				d.periph_power_off = 1'b1;
				d.sram_retain = 1'b0;
				d.port_hold = 1'b1;
				d.wake_unit_en = 1'b1;
				d.por_detect_en = por_en;
			end
			default: begin
				d.ctrl_run = 1'b1;
			end
		endcase
		return d;
	endfunction

	function automatic lpmw_pkg::lpmw_mode_e stop_mode(input logic [2:0] s);
		unique case (s)
			3'h1: stop_mode = lpmw_pkg::LPMW_REDUCED_STOP;
			3'h2: stop_mode = lpmw_pkg::LPMW_LEAKAGE_STOP;
			3'h3: stop_mode = lpmw_pkg::LPMW_DEEP_RAM;
			3'h4: stop_mode = lpmw_pkg::LPMW_DEEP_FILE;
			3'h5: stop_mode = lpmw_pkg::LPMW_DEEP_MIN;
			default: stop_mode = lpmw_pkg::LPMW_STOP;
		endcase
	endfunction

	// Index wraps at the top so software can stream the whole file
	function automatic logic [lpmw_pkg::LPMW_FILE_IDX_W-1:0] next_idx(
			input logic [lpmw_pkg::LPMW_FILE_IDX_W-1:0] i);
		return i + {{(lpmw_pkg::LPMW_FILE_IDX_W-1){1'b0}}, 1'b1};
	endfunction

	always_comb begin
		mod_src = '0;
		mod_src[lpmw_pkg::LPMW_SLOT_TIMER] = low_power_timer_wake_in;
		mod_src[lpmw_pkg::LPMW_SLOT_CMP] = cmp_wake_in;
		mod_src[lpmw_pkg::wake_slot_clock_alarm] = clock_alarm_wake_in;
		mod_src[lpmw_pkg::wake_slot_clock_seconds] = clock_seconds_wake_in;
	end

	assign sleep_req = wait_for_interrupt_instr_in | wait_for_event_instr_in;
	// Unit sees events only while enabled: in leakage modes or pending deep ack
	assign pin_hit = |(wake_pin_in & state_reg.pin_en);
	assign mod_hit = |(mod_src & state_reg.mod_en & lpmw_pkg::LPMW_MOD_VALID);
	assign wake_hit = state_reg.wake_active & (pin_hit | mod_hit);
	assign file_wr = reg_wr_in && (reg_addr_in == lpmw_pkg::LPMW_OFS_FDAT);

	always_comb begin
		state_next = state_reg;
		state_next.rdata = '0;
		leaving_deep = 1'b0;

		if (reg_wr_in) begin
			unique case (reg_addr_in)
				lpmw_pkg::LPMW_OFS_CTRL: state_next.ctrl = reg_wdata_in;
				lpmw_pkg::LPMW_OFS_PINFLG:
					state_next.pin_flag = state_reg.pin_flag & ~reg_wdata_in;
				lpmw_pkg::LPMW_OFS_MODFLG:
					state_next.mod_flag = state_reg.mod_flag & ~reg_wdata_in;
				lpmw_pkg::LPMW_OFS_PINEN: state_next.pin_en = reg_wdata_in;
				lpmw_pkg::LPMW_OFS_MODEN:
					state_next.mod_en = reg_wdata_in & lpmw_pkg::LPMW_MOD_VALID;
				lpmw_pkg::LPMW_OFS_IRQMSK: state_next.irq_msk = reg_wdata_in[2:0];
				lpmw_pkg::LPMW_OFS_FIDX:
					state_next.file_idx = reg_wdata_in[lpmw_pkg::LPMW_FILE_IDX_W-1:0];
				lpmw_pkg::LPMW_OFS_FDAT: state_next.file_idx = next_idx(state_reg.file_idx);
				default: state_next.ctrl = state_reg.ctrl;
			endcase
		end

		if (reg_rd_in) begin
			unique case (reg_addr_in)
				lpmw_pkg::LPMW_OFS_CTRL: state_next.rdata = state_reg.ctrl;
				lpmw_pkg::LPMW_OFS_MODE: state_next.rdata = {4'h0, state_reg.mode};
				lpmw_pkg::LPMW_OFS_PINFLG: state_next.rdata = state_reg.pin_flag;
				lpmw_pkg::LPMW_OFS_MODFLG: state_next.rdata = state_reg.mod_flag;
				lpmw_pkg::LPMW_OFS_PINEN: state_next.rdata = state_reg.pin_en;
				lpmw_pkg::LPMW_OFS_MODEN: state_next.rdata = state_reg.mod_en;
				lpmw_pkg::LPMW_OFS_IRQST: begin
					state_next.rdata = {5'h00, state_reg.irq_st};
					state_next.irq_st = '0;
				end
				lpmw_pkg::LPMW_OFS_IRQMSK: state_next.rdata = {5'h00, state_reg.irq_msk};
				lpmw_pkg::LPMW_OFS_FIDX: state_next.rdata = 8'(state_reg.file_idx);
				lpmw_pkg::LPMW_OFS_FDAT: begin
					state_next.rdata = file_mem[state_reg.file_idx];
					state_next.file_idx = next_idx(state_reg.file_idx);
				end
				default: state_next.rdata = '0;
			endcase
		end

		// Flags set after clears so a same-cycle event is kept
		if (state_reg.wake_active) begin
			state_next.pin_flag = state_next.pin_flag | (wake_pin_in & state_reg.pin_en);
			state_next.mod_flag = state_next.mod_flag |
				(mod_src & state_reg.mod_en & lpmw_pkg::LPMW_MOD_VALID);
		end

		unique case (state_reg.mode)
			lpmw_pkg::LPMW_RUN, lpmw_pkg::LPMW_REDUCED_RUN: begin
				if (sleep_req) begin
					state_next.irq_st[lpmw_pkg::LPMW_IRQ_ENTER] = 1'b1;
					if (!state_reg.ctrl[lpmw_pkg::LPMW_CTRL_SLEEPDEEP]) begin
						state_next.mode = state_reg.ctrl[lpmw_pkg::LPMW_CTRL_REDUCED] ?
							lpmw_pkg::LPMW_REDUCED_WAIT : lpmw_pkg::LPMW_WAIT;
					end else begin
						state_next.mode = stop_mode(
							state_reg.ctrl[lpmw_pkg::LPMW_CTRL_STOPSEL_LSB +: 3]);
						if (is_leak(state_next.mode)) begin
							state_next.wake_active = 1'b1;
						end
					end
				end else begin
					state_next.mode = state_reg.ctrl[lpmw_pkg::LPMW_CTRL_REDUCED] ?
						lpmw_pkg::LPMW_REDUCED_RUN : lpmw_pkg::LPMW_RUN;
				end
			end
			lpmw_pkg::LPMW_WAIT: begin
				if (vic_wake_in) begin
					state_next.mode = lpmw_pkg::LPMW_RUN;
				end
			end
			lpmw_pkg::LPMW_REDUCED_WAIT: begin
				if (vic_wake_in) begin
					state_next.mode = lpmw_pkg::LPMW_REDUCED_RUN;
				end
			end
			lpmw_pkg::LPMW_STOP, lpmw_pkg::LPMW_REDUCED_STOP: begin
				if (async_wake_in) begin
					state_next.mode = (state_reg.mode == lpmw_pkg::LPMW_REDUCED_STOP) ?
						lpmw_pkg::LPMW_REDUCED_RUN : lpmw_pkg::LPMW_RUN;
				end
			end
			lpmw_pkg::LPMW_LEAKAGE_STOP: begin
				if (wake_hit) begin
					state_next.mode = lpmw_pkg::LPMW_RUN;
					state_next.wake_active = 1'b0;
				end
			end
			lpmw_pkg::LPMW_DEEP_RAM, lpmw_pkg::LPMW_DEEP_FILE, lpmw_pkg::LPMW_DEEP_MIN: begin
				if (wake_hit) begin
					// Peripherals come back from reset
					state_next.mode = lpmw_pkg::LPMW_RUN;
					state_next.deep_pending = 1'b1;
					leaving_deep = 1'b1;
					state_next.irq_st[lpmw_pkg::LPMW_IRQ_DEEPW] = 1'b1;
				end
			end
			default: state_next.mode = lpmw_pkg::LPMW_RUN;
		endcase

		if (wake_hit) begin
			state_next.irq_st[lpmw_pkg::LPMW_IRQ_WAKE] = 1'b1;
		end

		// Detection stays on until all flags are cleared by software
		if (state_reg.deep_pending && !leaving_deep &&
				(state_next.pin_flag == '0) && (state_next.mod_flag == '0)) begin
			state_next.deep_pending = 1'b0;
			if (!is_leak(state_next.mode)) begin
				state_next.wake_active = 1'b0;
			end
		end

		state_next.dom = domains(state_next.mode, state_reg.ctrl[lpmw_pkg::LPMW_CTRL_POR_EN]);
	end

	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_reg <= '{
				ctrl:         lpmw_pkg::LPMW_CTRL_RST,
				pin_flag:     '0,
				mod_flag:     '0,
				pin_en:       '0,
				mod_en:       '0,
				irq_st:       '0,
				irq_msk:      '0,
				mode:         lpmw_pkg::LPMW_RUN,
				wake_active:  1'b0,
				deep_pending: 1'b0,
				file_idx:     '0,
				rdata:        '0,
				dom:          '0
			};
		end else begin
			state_reg <= state_next;
		end
	end

	// Only a power-on reset clears the file; deep levels never touch it
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			for (int i = 0; i < lpmw_pkg::LPMW_FILE_BYTES; i++) begin
				file_mem[i] <= '0;
			end
		end else if (file_wr) begin
			file_mem[state_reg.file_idx] <= reg_wdata_in;
		end
	end

	assign reg_rdata_out    = state_reg.rdata;
	assign mode_out         = state_reg.mode;
	assign domain_out       = state_reg.dom;
	assign periph_reset_out = state_reg.dom.periph_power_off;
	assign irq_out          = |(state_reg.irq_st & state_reg.irq_msk);

endmodule // lpmw_ctrl

//--- src/lpmw_pkg.sv
// Package for the low power mode and wake-up controller
package lpmw_pkg;

	typedef enum logic [1:0] {
		LPMW_SLEEP_WAIT,
		LPMW_SLEEP_STOP
	} lpmw_sleep_e;

	typedef enum logic [2:0] {
		LPMW_STOP_NORMAL,
		LPMW_STOP_REDUCED,
		LPMW_STOP_LEAKAGE,
		LPMW_STOP_DEEP_RAM,
		LPMW_STOP_DEEP_FILE,
		LPMW_STOP_DEEP_MIN
	} lpmw_stop_sel_e;

	typedef enum logic [3:0] {
		LPMW_RUN,
		LPMW_REDUCED_RUN,
		LPMW_WAIT,
		LPMW_REDUCED_WAIT,
		LPMW_STOP,
		LPMW_REDUCED_STOP,
		LPMW_LEAKAGE_STOP,
		LPMW_DEEP_RAM,
		LPMW_DEEP_FILE,
		LPMW_DEEP_MIN
	} lpmw_mode_e;

	// Register offsets
	localparam logic [3:0] LPMW_OFS_CTRL   = 4'h0;
	localparam logic [3:0] LPMW_OFS_MODE   = 4'h1;
	localparam logic [3:0] LPMW_OFS_PINFLG = 4'h2;
	localparam logic [3:0] LPMW_OFS_MODFLG = 4'h3;
	localparam logic [3:0] LPMW_OFS_PINEN  = 4'h4;
	localparam logic [3:0] LPMW_OFS_MODEN  = 4'h5;
	localparam logic [3:0] LPMW_OFS_IRQST  = 4'h6;
	localparam logic [3:0] LPMW_OFS_IRQMSK = 4'h7;
	localparam logic [3:0] LPMW_OFS_FIDX   = 4'h8;
	localparam logic [3:0] LPMW_OFS_FDAT   = 4'h9;

	// Backup register file
	localparam int LPMW_FILE_BYTES = 32;
	localparam int LPMW_FILE_IDX_W = 5;

	// Control field positions
	localparam int LPMW_CTRL_STOPSEL_LSB = 0;
	localparam int LPMW_CTRL_REDUCED     = 4;
	localparam int LPMW_CTRL_SLEEPDEEP   = 5;
	localparam int LPMW_CTRL_POR_EN      = 6;
	localparam logic [7:0] LPMW_CTRL_RST = 8'h40;

	// Internal slot layout, slots 2,3,4,6 reserved
	localparam logic [7:0] LPMW_MOD_VALID = 8'ha3;
	localparam int LPMW_SLOT_TIMER   = 0;
	localparam int LPMW_SLOT_CMP     = 1;
	localparam int wake_slot_clock_alarm   = 5;
	localparam int wake_slot_clock_seconds = 7;

	// Interrupt status bits
	localparam int LPMW_IRQ_ENTER = 0;
	localparam int LPMW_IRQ_WAKE  = 1;
	localparam int LPMW_IRQ_DEEPW = 2;

	typedef struct packed {
		logic low_voltage_monitor_en;
		logic reduced_clock;
		logic core_clock_en;
		logic periph_clock_en;
		logic static_freeze;
		logic periph_power_off;
		logic sram_retain;
		logic file_retain;
		logic cmp_run;
		logic adc_run;
		logic timer_run;
		logic clock_run;
		logic pin_irq_run;
		logic dma_group_run;
		logic vic_en;
		logic async_wake_controller_en;
		logic wake_unit_en;
		logic ctrl_run;
		logic port_hold;
		logic por_detect_en;
	} lpmw_dom_s;

	typedef struct packed {
		logic [7:0]     ctrl;
		logic [7:0]     pin_flag;
		logic [7:0]     mod_flag;
		logic [7:0]     pin_en;
		logic [7:0]     mod_en;
		logic [2:0]     irq_st;
		logic [2:0]     irq_msk;
		lpmw_mode_e     mode;
		logic           wake_active;
		logic           deep_pending;
		logic [7:0]     rdata;
		logic [LPMW_FILE_IDX_W-1:0] file_idx;
		lpmw_dom_s      dom;
	} lpmw_state_s;

endpackage

//--- dv/lpmw_ctrl_monitor.sv
// Port checker for the low power mode controller
`timescale 1ns/10ps
module lpmw_ctrl_monitor (
	// Clock and reset
	input wire logic                 ref_clk_in,
	input wire logic                 reset_n_in,
	// Requests
	input wire logic                 wait_for_interrupt_instr_in,
	input wire logic                 wait_for_event_instr_in,
	input wire logic                 vic_wake_in,
	input wire logic                 async_wake_in,
	// Watched outputs
	input wire lpmw_pkg::lpmw_mode_e mode_out,
	input wire lpmw_pkg::lpmw_dom_s  domain_out,
	input wire logic                 periph_reset_out
);
	default clocking cb @(posedge ref_clk_in); endclocking
	default disable iff (!reset_n_in);

	a_sleep_leaves_run: assert property (mode_out <= lpmw_pkg::LPMW_REDUCED_RUN &&
		(wait_for_interrupt_instr_in || wait_for_event_instr_in) |=> mode_out >= lpmw_pkg::LPMW_WAIT)
		else $error("sleep request kept run class");
	a_reduced_run_slow: assert property (mode_out == lpmw_pkg::LPMW_REDUCED_RUN |->
		domain_out.reduced_clock && !domain_out.low_voltage_monitor_en)
		else $error("reduced run domains wrong");
	a_wait_core_sleeps: assert property (mode_out == lpmw_pkg::LPMW_WAIT |->
		!domain_out.core_clock_en && domain_out.periph_clock_en)
		else $error("wait domains wrong");
	a_reduced_wait_slow: assert property (mode_out == lpmw_pkg::LPMW_REDUCED_WAIT |->
		!domain_out.core_clock_en && domain_out.reduced_clock && !domain_out.low_voltage_monitor_en)
		else $error("reduced wait domains wrong");
	a_stop_retains_all: assert property (mode_out == lpmw_pkg::LPMW_STOP |->
		domain_out.static_freeze && domain_out.sram_retain && domain_out.low_voltage_monitor_en &&
		domain_out.adc_run && domain_out.timer_run && domain_out.pin_irq_run)
		else $error("stop domains wrong");
	a_reduced_stop_kept: assert property (mode_out == lpmw_pkg::LPMW_REDUCED_STOP |->
		domain_out.sram_retain && domain_out.dma_group_run && !domain_out.vic_en &&
		!domain_out.low_voltage_monitor_en)
		else $error("reduced stop domains wrong");
	a_leakage_freezes: assert property (mode_out == lpmw_pkg::LPMW_LEAKAGE_STOP |->
		domain_out.file_retain && domain_out.port_hold && domain_out.cmp_run && !domain_out.adc_run)
		else $error("leakage stop domains wrong");
	a_deep_power_off: assert property (mode_out >= lpmw_pkg::LPMW_DEEP_RAM |->
		periph_reset_out && domain_out.wake_unit_en)
		else $error("deep stop not powered off");
	a_deep_timer_runs: assert property (mode_out >= lpmw_pkg::LPMW_DEEP_RAM |->
		domain_out.timer_run && domain_out.clock_run)
		else $error("deep stop halted timer or clock");
	a_wait_vic_wakes: assert property (mode_out == lpmw_pkg::LPMW_WAIT && vic_wake_in |=>
		mode_out == lpmw_pkg::LPMW_RUN)
		else $error("wait did not wake on vic");
	a_stop_async_wakes: assert property (mode_out == lpmw_pkg::LPMW_STOP && async_wake_in |=>
		mode_out == lpmw_pkg::LPMW_RUN)
		else $error("stop did not wake on async");
endmodule // lpmw_ctrl_monitor

bind lpmw_ctrl lpmw_ctrl_monitor i_lpmw_ctrl_monitor (.ref_clk_in, .reset_n_in,
	.wait_for_interrupt_instr_in, .wait_for_event_instr_in, .vic_wake_in, .async_wake_in,
	.mode_out, .domain_out, .periph_reset_out);

//--- dv/lpmw_far_model.sv
// Far-side model of core and peripheral wake sources
`timescale 1ns/10ps
module lpmw_far_model (
	// Clock, reset and requests
	input  wire logic        ref_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic [13:0] req_in,
	// Wake lines
	output logic      [7:0]  wake_pin_out,
	output logic      [3:0]  wake_mod_out,
	output logic             vic_wake_out,
	output logic             async_wake_out
);
	// Registered like a source in another logic block, never same-cycle
	always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			{async_wake_out, vic_wake_out, wake_mod_out, wake_pin_out} <= 14'h0000;
		end else begin
			{async_wake_out, vic_wake_out, wake_mod_out, wake_pin_out} <= req_in;
		end
	end
endmodule // lpmw_far_model

//--- dv/tb_lpmw_ctrl.sv
// Testbench for the low power mode and wake-up controller
`timescale 1ns/10ps
module tb_lpmw_ctrl;
	logic                 ref_clk_in, reset_n_in, reg_wr_in, reg_rd_in, wait_for_interrupt_instr, wait_for_event_instr;
	logic                 vic, awk, periph_reset_out, irq_out;
	logic [3:0]           reg_addr_in, mods;
	logic [7:0]           reg_wdata_in, reg_rdata_out, pins, rd;
	logic [13:0]          req;
	lpmw_pkg::lpmw_mode_e mode_out;
	lpmw_pkg::lpmw_dom_s  domain_out;
	int                   failures, tests_run;

	lpmw_far_model i_lpmw_far_model (.ref_clk_in, .reset_n_in, .req_in(req), .wake_pin_out(pins),
		.wake_mod_out(mods), .vic_wake_out(vic), .async_wake_out(awk));
	lpmw_ctrl i_lpmw_ctrl (.ref_clk_in, .reset_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
		.reg_rd_in, .reg_rdata_out, .wait_for_interrupt_instr_in(wait_for_interrupt_instr),
		.wait_for_event_instr_in(wait_for_event_instr), .vic_wake_in(vic), .async_wake_in(awk), .wake_pin_in(pins),
		.low_power_timer_wake_in(mods[0]), .cmp_wake_in(mods[1]), .clock_alarm_wake_in(mods[2]),
		.clock_seconds_wake_in(mods[3]), .mode_out, .domain_out, .periph_reset_out, .irq_out);

	initial begin
		ref_clk_in = 1'b0;
		forever #5 ref_clk_in = !ref_clk_in;
	end

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_sim();
		$display("failures %0d tests_run %0d", failures, tests_run);
		if (failures == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_wdata_in <= d;
		reg_wr_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_wr_in <= 1'b0;
	endtask
	task automatic rdr(input logic [3:0] a);
		@(posedge ref_clk_in);
		reg_addr_in <= a;
		reg_rd_in <= 1'b1;
		@(posedge ref_clk_in);
		reg_rd_in <= 1'b0;
		#1 rd = reg_rdata_out;
	endtask
	task automatic hold(input int n);
		repeat (n) @(posedge ref_clk_in);
		#1;
	endtask
	task automatic set_req(input logic [13:0] v);
		@(posedge ref_clk_in);
		req <= v;
	endtask
	task automatic sleep(input logic ev);
		@(posedge ref_clk_in);
		wait_for_interrupt_instr <= !ev;
		wait_for_event_instr <= ev;
		@(posedge ref_clk_in);
		wait_for_interrupt_instr <= 1'b0;
		wait_for_event_instr <= 1'b0;
	endtask
	// A stuck mode ends the run at once, later steps would only cascade
	task automatic wait_mode(input lpmw_pkg::lpmw_mode_e exp);
		for (int i = 0; i < 8 && mode_out !== exp; i++) begin
			hold(1);
		end
		chk(8'(mode_out), 8'(exp));
		if (mode_out !== exp) begin
			end_sim();
		end
	endtask

	// Offsets: 0 ctrl, 1 mode, 2/3 flags, 4/5 enables, 6 irq status, 7 irq mask, 8/9 file
	task automatic t_regs();
		rdr(4'h0);
		chk(rd, lpmw_pkg::LPMW_CTRL_RST);
		wr(4'hf, 8'h55);
		rdr(4'hf);
		chk(rd, 8'h00);
		wr(4'h1, 8'h09);
		rdr(4'h1);
		chk(rd, 8'h00);
		wr(4'h5, 8'hff);
		rdr(4'h5);
		chk(rd, 8'ha3);
		wr(4'h4, 8'hff);
		wr(4'h7, 8'h00);
	endtask
	// Domain slices: [19] monitor, [18] reduced, [17] core, [16] periph
	task automatic t_run();
		sleep(1'b0);
		wait_mode(lpmw_pkg::LPMW_WAIT);
		chk(8'(domain_out[17:16]), 8'h01);
		set_req(14'h2000);
		hold(3);
		chk(8'(mode_out), 8'(lpmw_pkg::LPMW_WAIT));
		set_req(14'h1000);
		wait_mode(lpmw_pkg::LPMW_RUN);
		set_req(14'h0000);
		wr(4'h0, 8'h10);
		wait_mode(lpmw_pkg::LPMW_REDUCED_RUN);
		chk(8'(domain_out[19:18]), 8'h01);
		sleep(1'b1);
		wait_mode(lpmw_pkg::LPMW_REDUCED_WAIT);
		chk(8'(domain_out[19:17]), 8'h02);
		set_req(14'h1000);
		wait_mode(lpmw_pkg::LPMW_REDUCED_RUN);
		set_req(14'h0000);
		wr(4'h0, 8'h00);
		wait_mode(lpmw_pkg::LPMW_RUN);
	endtask
	task automatic t_stop();
		logic [7:0] ctl [7] = '{8'h20, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h65};
		logic [2:0] sel;
		for (int k = 0; k < 7; k++) begin
			sel = ctl[k][2:0];
			wr(4'h0, ctl[k]);
			sleep(1'b0);
			wait_mode(lpmw_pkg::lpmw_mode_e'(4'h4 + sel));
			chk(8'(irq_out), 8'h00);
			chk(8'({domain_out[13], domain_out[11]}), 8'({sel < 3'h4, sel != 3'h5}));
			if (sel == 3'h5) begin
				chk(8'(domain_out.por_detect_en), 8'(ctl[k][6]));
			end
			// Wrong wake path first: it must not wake this mode
			set_req(sel < 3'h2 ? 14'h1000 : 14'h2000);
			hold(3);
			chk(8'(mode_out), 8'(4'h4 + sel));
			set_req(sel < 3'h2 ? 14'h2000 : 14'h0001);
			wait_mode(lpmw_pkg::LPMW_RUN);
			set_req(14'h0000);
			wr(4'h2, 8'hff);
		end
	endtask
	task automatic t_flags();
		wr(4'h0, 8'h22);
		rdr(4'h6);
		wr(4'h7, 8'h02);
		sleep(1'b0);
		wait_mode(lpmw_pkg::LPMW_LEAKAGE_STOP);
		set_req(14'h0080);
		wait_mode(lpmw_pkg::LPMW_RUN);
		chk(8'(irq_out), 8'h01);
		rdr(4'h2);
		chk(rd, 8'h80);
		rdr(4'h6);
		chk(rd, 8'h03);
		hold(1);
		chk(8'(irq_out), 8'h00);
		set_req(14'h0040);
		wr(4'h2, 8'hff);
		hold(3);
		rdr(4'h2);
		chk(rd, 8'h00);
		set_req(14'h0000);
		wr(4'h0, 8'h24);
		sleep(1'b0);
		wait_mode(lpmw_pkg::LPMW_DEEP_FILE);
		set_req(14'h0400);
		wait_mode(lpmw_pkg::LPMW_RUN);
		chk(8'(periph_reset_out), 8'h00);
		// Timer, alarm and seconds after wake: unit still listening
		set_req(14'h0d00);
		hold(3);
		rdr(4'h3);
		chk(rd, 8'ha1);
		rdr(4'h6);
		chk(rd & 8'h04, 8'h04);
		set_req(14'h0000);
		wr(4'h3, 8'hff);
		set_req(14'h0200);
		hold(3);
		rdr(4'h3);
		chk(rd, 8'h00);
		set_req(14'h0000);
	endtask
	// Backup file across the deepest level; index wraps at the top
	task automatic t_file();
		wr(4'h8, 8'h1e);
		wr(4'h9, 8'h5a);
		wr(4'h9, 8'hc3);
		rdr(4'h8);
		chk(rd, 8'h00);
		wr(4'h0, 8'h25);
		sleep(1'b0);
		wait_mode(lpmw_pkg::LPMW_DEEP_MIN);
		chk(8'(domain_out[12:8]), 8'h13);
		set_req(14'h0001);
		wait_mode(lpmw_pkg::LPMW_RUN);
		set_req(14'h0000);
		wr(4'h2, 8'hff);
		wr(4'h8, 8'h1e);
		rdr(4'h9);
		chk(rd, 8'h5a);
		rdr(4'h9);
		chk(rd, 8'hc3);
	endtask

	initial begin
		reset_n_in = 1'b0;
		{reg_wr_in, reg_rd_in, wait_for_interrupt_instr, wait_for_event_instr} = 4'h0;
		reg_addr_in = 4'h0;
		reg_wdata_in = 8'h00;
		req = 14'h0000;
		failures = 0;
		tests_run = 0;
		repeat (12) @(posedge ref_clk_in);
		reset_n_in <= 1'b1;
		t_regs();
		t_run();
		t_stop();
		t_flags();
		t_file();
		end_sim();
	end
endmodule // tb_lpmw_ctrl
